// file: design/slpc_defs.svh
// Timing constants of the sleep control and ring indicator block.
// Assumes the system clock rate given by SLPC_CLK_HZ.
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH
`define SLPC_CLK_HZ           64'd50000000
`define SLPC_RI_CALL_LOW_MS   64'd30
`define SLPC_RI_CALL_PER_MS   64'd5000
`define SLPC_RI_SMS_LOW_MS    64'd35
`define SLPC_SLEEP_RETURN_S   64'd120
`define SLPC_BLINK_TICK_MS    64'd100
`define SLPC_MAX_BAUD         64'd4000000
`define SLPC_RI_CALL_LOW_CYC  (`SLPC_CLK_HZ / 64'd1000 * `SLPC_RI_CALL_LOW_MS)
`define SLPC_RI_CALL_PER_CYC  (`SLPC_CLK_HZ / 64'd1000 * `SLPC_RI_CALL_PER_MS)
`define SLPC_RI_SMS_LOW_CYC   (`SLPC_CLK_HZ / 64'd1000 * `SLPC_RI_SMS_LOW_MS)
`define SLPC_SLEEP_RETURN_CYC (`SLPC_CLK_HZ * `SLPC_SLEEP_RETURN_S)
`define SLPC_BLINK_TICK_CYC   (`SLPC_CLK_HZ / 64'd1000 * `SLPC_BLINK_TICK_MS)
`define SLPC_BLINK_PHASES     4'd10
`endif

// file: design/slpc_pkg.sv
// Types shared by the sleep control and ring indicator block.
// Assumes nothing of its surroundings.
package slpc_pkg;
  typedef enum logic [4:0] {
    SLPC_AWAKE   = 5'b00001,
    SLPC_DRAIN   = 5'b00010,
    SLPC_ASLEEP  = 5'b00100,
    SLPC_SERVICE = 5'b01000,
    SLPC_HOLDOFF = 5'b10000
  } slpc_sleep_type;
  typedef enum logic [3:0] {
    SLPC_RI_IDLE      = 4'b0001,
    SLPC_RI_CALL_LOW  = 4'b0010,
    SLPC_RI_CALL_HIGH = 4'b0100,
    SLPC_RI_SMS_LOW   = 4'b1000
  } slpc_ring_type;
  typedef enum logic [1:0] {
    SLPC_NET_SEARCH = 2'h0,
    SLPC_NET_IDLE   = 2'h1,
    SLPC_NET_DATA   = 2'h2,
    SLPC_NET_OFF    = 2'h3
  } slpc_net_type;
endpackage

// file: design/slpc_top.sv
// Sleep control, ring indicator, network status blink, boot strap and serial flow control.
// Assumes all inputs except rst_n are synchronous to sys_clk and rst_n is the power-on reset.
`timescale 1ns/10ps
`include "slpc_defs.svh"
// Overview of operation
// R01 - Power save enable gates terminal-ready sleep control.
// R02 - Host keeps terminal-ready high when working.
// R03 - Terminal-ready low while enabled and idle sleeps.
// R04 - Sleep waits for processing and transfers finishing.
// R05 - Terminal-ready high wakes the module fully.
// R06 - Call, data or message wakes; notification sent.
// R07 - Host raises terminal-ready, then lowers after handling.
// R08 - Terminal-ready low: resleep two minutes after service.
// R09 - Incoming call: 30 ms low every 5 s.
// R10 - Answered call: ring indicator returns high.
// R11 - Short message: one 35 ms low pulse.
// R12 - Network status blinks per state, selectable style.
// R13 - Strap high at startup selects download boot.
// R14 - Serial port has request and clear flow control.
// R15 - Ring indicator idles high, also after reset.
module slpc_top #(
  parameter logic [32:0] SLEEP_RETURN_CYC = 33'(`SLPC_SLEEP_RETURN_CYC),
  parameter logic [27:0] RI_CALL_LOW_CYC  = 28'(`SLPC_RI_CALL_LOW_CYC),
  parameter logic [27:0] RI_CALL_PER_CYC  = 28'(`SLPC_RI_CALL_PER_CYC),
  parameter logic [27:0] RI_SMS_LOW_CYC   = 28'(`SLPC_RI_SMS_LOW_CYC),
  parameter logic [27:0] BLINK_TICK_CYC   = 28'(`SLPC_BLINK_TICK_CYC)
) (
  input  wire logic                 sys_clk,                    // System clock, 50 MHz.
  input  wire logic                 rst_n,                      // Asynchronous reset.
  input  wire logic                 power_save_enable_command,  // Sleep enabled setting.
  input  wire logic                 terminal_ready,             // Host sleep control line.
  input  wire logic                 work_busy,                  // Processing or data pending.
  input  wire logic                 wake_call,                  // Incoming call event pulse.
  input  wire logic                 wake_data,                  // Received data event pulse.
  input  wire logic                 wake_sms,                   // Received message pulse.
  input  wire logic                 call_ringing,               // Call incoming, unanswered.
  input  wire slpc_pkg::slpc_net_type net_state,                // Module network state.
  input  wire logic [1:0]           blink_style,                // Configured blink style.
  input  wire logic                 force_boot_strap,           // Download boot strap level.
  input  wire logic                 serial_clear_to_send_in_n,  // Far end ready, low.
  input  wire logic                 rx_room,                    // Receive path has space.
  output logic                      sleep_active,               // Module is asleep.
  output logic                      wake_notify,                // Unsolicited message pulse.
  output logic                      ring_text,                  // Ring text request pulse.
  output logic                      ring_indicator,             // Ring pin, idles high.
  output logic                      network_status_indicator,   // Blink output.
  output logic                      download_boot,              // Download boot selected.
  output logic                      serial_request_to_send_out_n, // Ready to receive, low.
  output logic                      tx_permit                   // Transmitter may send.
);
  import slpc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_sys_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sys_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Sleep control
  // ----------------------------------------------------------------
  slpc_sleep_type slp_q, slp_d;
  logic [32:0]    ret_q, ret_d;
  logic           notify_d;
  logic           wake_ev;
  assign wake_ev = wake_call | wake_data | wake_sms;

  always_comb begin
    slp_d    = slp_q;
    ret_d    = ret_q;
    notify_d = 1'b0;
    case (slp_q)
      SLPC_AWAKE: begin
        // R01 R03 enabled low entry
        if (power_save_enable_command && !terminal_ready) begin
          slp_d = SLPC_DRAIN;
        end
      end
      SLPC_DRAIN: begin
        // R04 wait for idle
        if (!power_save_enable_command || terminal_ready) begin
          slp_d = SLPC_AWAKE;
        end else if (!work_busy) begin
          slp_d = SLPC_ASLEEP;
        end
      end
      SLPC_ASLEEP: begin
        // R05 R06 wake sources
        if (!power_save_enable_command || terminal_ready) begin
          slp_d = SLPC_AWAKE;
        end else if (wake_ev) begin
          slp_d    = SLPC_SERVICE;
          notify_d = 1'b1;
        end
      end
      SLPC_SERVICE: begin
        if (!power_save_enable_command || terminal_ready) begin
          slp_d = SLPC_AWAKE;
        end else if (!work_busy) begin
          slp_d = SLPC_HOLDOFF;
          ret_d = 33'h0;
        end
      end
      SLPC_HOLDOFF: begin
        // R08 timed return to sleep
        if (!power_save_enable_command || terminal_ready) begin
          slp_d = SLPC_AWAKE;
        end else if (wake_ev || work_busy) begin
          slp_d = SLPC_SERVICE;
        end else if (ret_q == SLEEP_RETURN_CYC - 33'h1) begin
          slp_d = SLPC_ASLEEP;
        end else begin
          ret_d = ret_q + 33'h1;
        end
      end
      default: slp_d = SLPC_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      slp_q        <= SLPC_AWAKE;
      ret_q        <= 33'h0;
      wake_notify  <= 1'b0;
      sleep_active <= 1'b0;
    end else begin
      slp_q        <= slp_d;
      ret_q        <= ret_d;
      wake_notify  <= notify_d;
      sleep_active <= (slp_d == SLPC_ASLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Ring indicator
  // ----------------------------------------------------------------
  // A message arriving during a ringing call is not signalled; the call pattern wins.
  slpc_ring_type ri_q, ri_d;
  logic [27:0]   ri_cnt_q, ri_cnt_d;
  logic          ring_text_d;

  always_comb begin
    ri_d        = ri_q;
    ri_cnt_d    = ri_cnt_q + 28'h1;
    ring_text_d = 1'b0;
    case (ri_q)
      SLPC_RI_IDLE: begin
        ri_cnt_d = 28'h0;
        if (call_ringing) begin
          ri_d        = SLPC_RI_CALL_LOW;
          ring_text_d = 1'b1;
        end else if (wake_sms) begin
          ri_d = SLPC_RI_SMS_LOW;
        end
      end
      SLPC_RI_CALL_LOW: begin
        // R09 R10 call pulse train
        if (!call_ringing) begin
          ri_d = SLPC_RI_IDLE;
        end else if (ri_cnt_q == RI_CALL_LOW_CYC - 28'h1) begin
          ri_d = SLPC_RI_CALL_HIGH;
        end
      end
      SLPC_RI_CALL_HIGH: begin
        if (!call_ringing) begin
          ri_d = SLPC_RI_IDLE;
        end else if (ri_cnt_q == RI_CALL_PER_CYC - 28'h1) begin
          ri_d        = SLPC_RI_CALL_LOW;
          ri_cnt_d    = 28'h0;
          ring_text_d = 1'b1;
        end
      end
      SLPC_RI_SMS_LOW: begin
        // R11 single message pulse
        if (ri_cnt_q == RI_SMS_LOW_CYC - 28'h1) begin
          ri_d = SLPC_RI_IDLE;
        end
      end
      default: ri_d = SLPC_RI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      ri_q           <= SLPC_RI_IDLE;
      ri_cnt_q       <= 28'h0;
      ring_text      <= 1'b0;
      // R15 idle high
      ring_indicator <= 1'b1;
    end else begin
      ri_q           <= ri_d;
      ri_cnt_q       <= ri_cnt_d;
      ring_text      <= ring_text_d;
      ring_indicator <= !(ri_d == SLPC_RI_CALL_LOW || ri_d == SLPC_RI_SMS_LOW);
    end
  end

  // ----------------------------------------------------------------
  // Network status blink, strap and flow control
  // ----------------------------------------------------------------
  logic [27:0] tick_q, tick_d;
  logic [3:0]  phase_q, phase_d;
  logic        led_d;
  logic        strap_done_q;

  always_comb begin
    tick_d  = tick_q + 28'h1;
    phase_d = phase_q;
    if (tick_q == BLINK_TICK_CYC - 28'h1) begin
      tick_d  = 28'h0;
      phase_d = (phase_q == `SLPC_BLINK_PHASES - 4'd1) ? 4'd0 : phase_q + 4'd1;
    end
    // R12 pattern per state
    case (net_state)
      SLPC_NET_SEARCH: led_d = blink_style[0] ? phase_q[0] : (phase_q < 4'd5);
      SLPC_NET_IDLE:   led_d = (phase_q == 4'd0) || (blink_style[1] && phase_q == 4'd2);
      SLPC_NET_DATA:   led_d = blink_style[0] ? (phase_q < 4'd8) : phase_q[0];
      default:         led_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      tick_q                       <= 28'h0;
      phase_q                      <= 4'd0;
      network_status_indicator     <= 1'b0;
      strap_done_q                 <= 1'b0;
      download_boot                <= 1'b0;
      serial_request_to_send_out_n <= 1'b1;
      tx_permit                    <= 1'b0;
    end else begin
      tick_q                       <= tick_d;
      phase_q                      <= phase_d;
      network_status_indicator     <= led_d;
      strap_done_q                 <= 1'b1;
      // R13 strap caught once
      if (!strap_done_q) begin
        download_boot <= force_boot_strap;
      end
      // R14 hardware flow control
      serial_request_to_send_out_n <= !rx_room;
      tx_permit                    <= !serial_clear_to_send_in_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_gate_by_enable: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R01
    !power_save_enable_command |=> !sleep_active) else $error("asleep while disabled");
  chk_busy_defers: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R04
    (slp_q == SLPC_DRAIN && work_busy) |=> !sleep_active) else $error("slept while busy");
  chk_enter_sleep: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R03
    (slp_q == SLPC_DRAIN && !work_busy && !terminal_ready && power_save_enable_command)
    |=> sleep_active) else $error("idle low did not sleep");
  chk_ready_wakes: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R05
    (sleep_active && terminal_ready) |=> (slp_q == SLPC_AWAKE && !sleep_active))
    else $error("terminal ready did not wake");
  chk_event_notify: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R06
    (slp_q == SLPC_ASLEEP && wake_ev && !terminal_ready && power_save_enable_command)
    |=> (wake_notify && slp_q == SLPC_SERVICE) ##1 !wake_notify) else $error("no notify");
  chk_resleep_time: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R08
    (slp_q == SLPC_HOLDOFF && $past(slp_q) == SLPC_SERVICE) |-> ret_q == 33'h0)
    else $error("holdoff count not restarted");
  chk_holdoff_early: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R08
    (slp_q == SLPC_HOLDOFF && ret_q != SLEEP_RETURN_CYC - 33'h1) |=> !sleep_active)
    else $error("returned to sleep early");
  chk_call_low: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R09
    (ri_q == SLPC_RI_CALL_LOW && call_ringing && ri_cnt_q < RI_CALL_LOW_CYC - 28'h1)
    |=> !ring_indicator) else $error("call pulse too short");
  chk_answer_high: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R10
    ((ri_q == SLPC_RI_CALL_LOW || ri_q == SLPC_RI_CALL_HIGH) && !call_ringing)
    |=> (ring_indicator && ri_q == SLPC_RI_IDLE)) else $error("ring low after answer");
  chk_sms_pulse: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R11
    (ri_q == SLPC_RI_SMS_LOW && ri_cnt_q == RI_SMS_LOW_CYC - 28'h1) |=> ring_indicator)
    else $error("message pulse length wrong");
  chk_idle_high: assert property (@(posedge sys_clk) disable iff (!rst_sys_n) // R15
    (ri_q == SLPC_RI_IDLE) |-> ring_indicator) else $error("ring low while idle");
endmodule

// file: verification/slpc_host_model.sv
// Behavioural host controller that drives the terminal-ready line.
// Assumes wake_notify is a one-cycle pulse launched on a rising edge of sys_clk.
`timescale 1ns/10ps
module slpc_host_model #(
  parameter int HANDLE_CYC = 8
) (
  input  wire logic sys_clk,        // System clock.
  input  wire logic rst_n,          // Reset, active low.
  input  wire logic want_sleep,     // Bench asks the host to let the module sleep.
  input  wire logic respond_en,     // Host answers wake notifications.
  input  wire logic wake_notify,    // Unsolicited message pulse from the module.
  output logic      terminal_ready  // Host sleep control line.
);
  int handle_q;

  // --------------------------------------------------------------------
  // Line driving
  // --------------------------------------------------------------------
  // host line rules
  // The line changes only on falling edges, so the module never samples it mid-change.
  always @(negedge sys_clk) begin
    if (!rst_n) begin
      handle_q <= 0;
    end else if (respond_en && wake_notify) begin
      handle_q <= HANDLE_CYC;
    end else if (handle_q > 0) begin
      handle_q <= handle_q - 1;
    end
    terminal_ready <= !want_sleep || (respond_en && wake_notify) || (handle_q > 1);
  end
endmodule

// file: verification/test_sleep_control_and_ring_indicator.sv
// Self-checking bench for the sleep control and ring indicator block.
// Assumes the shortened timing parameters below; all counts derive from them.
`timescale 1ns/10ps
module test_sleep_control_and_ring_indicator;
  localparam int SRC = 40;
  localparam int LOWC = 3;
  localparam int PERC = 20;
  localparam int SMSC = 4;
  logic sys_clk, rst_n, en, busy, wc, wd, ws, ringing, strap, cts_n, rx_room;
  logic want_sleep, respond, tr, sleep_active, notify, ring_text, ring_ind, net_led, dl_boot;
  logic rts_n, tx_permit;
  logic [1:0] net, style;
  logic [49:0] sig [5];
  logic [3:0] rows [4] = '{4'b0011, 4'b0110, 4'b1001, 4'b1100};
  int bad_count, comparisons, n_low, n_txt, n_ntf;

  slpc_top #(.SLEEP_RETURN_CYC(33'(SRC)), .RI_CALL_LOW_CYC(28'(LOWC)), .RI_CALL_PER_CYC(28'(PERC)),
    .RI_SMS_LOW_CYC(28'(SMSC)), .BLINK_TICK_CYC(28'h5)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .power_save_enable_command(en), .terminal_ready(tr), .work_busy(busy), .wake_call(wc),
    .wake_data(wd), .wake_sms(ws), .call_ringing(ringing), .net_state(slpc_pkg::slpc_net_type'(net)),
    .blink_style(style), .force_boot_strap(strap), .serial_clear_to_send_in_n(cts_n),
    .rx_room(rx_room), .sleep_active(sleep_active), .wake_notify(notify), .ring_text(ring_text),
    .ring_indicator(ring_ind), .network_status_indicator(net_led), .download_boot(dl_boot),
    .serial_request_to_send_out_n(rts_n), .tx_permit(tx_permit));
  slpc_host_model u_host (.sys_clk(sys_clk), .rst_n(rst_n), .want_sleep(want_sleep),
    .respond_en(respond), .wake_notify(notify), .terminal_ready(tr));

  // --------------------------------------------------------------------
  // Clock, checking and closing
  // --------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wait_sleep(input logic v, input int lim);
    for (int i = 0; i < lim && sleep_active !== v; i++) @(negedge sys_clk);
  endtask
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    repeat (20) @(negedge sys_clk);
    chk(ring_ind, 1'b1);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    strap = !s;
    @(negedge sys_clk);
    chk(dl_boot, s);
    $display("reset test done");
  endtask
  task automatic watch(input int cyc);
    n_low = 0;
    n_txt = 0;
    n_ntf = 0;
    repeat (cyc) begin
      @(negedge sys_clk);
      wc = 1'b0;
      wd = 1'b0;
      ws = 1'b0;
      n_low += int'(ring_ind === 1'b0);
      n_txt += int'(ring_text === 1'b1);
      n_ntf += int'(notify === 1'b1);
    end
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    {bad_count, comparisons} = '0;
    {en, busy, wc, wd, ws, ringing, cts_n, rx_room, want_sleep, respond} = '0;
    net = 2'h0;
    style = 2'h0;
    do_reset(1'b1);
    foreach (rows[i]) begin
      {rx_room, cts_n} = rows[i][3:2];
      repeat (2) @(negedge sys_clk);
      chk({rts_n, tx_permit}, rows[i][1:0]);
    end
    $display("flow control test done");
    want_sleep = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(sleep_active, 1'b0);
    busy = 1'b1;
    en = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(sleep_active, 1'b0);
    busy = 1'b0;
    wait_sleep(1'b1, 4);
    chk(sleep_active, 1'b1);
    want_sleep = 1'b0;
    wait_sleep(1'b0, 3);
    chk(sleep_active, 1'b0);
    want_sleep = 1'b1;
    wait_sleep(1'b1, 4);
    $display("sleep entry test done");
    ws = 1'b1;
    watch(36);
    chk(8'(n_ntf), 8'h1);
    chk(8'(n_low), 8'(SMSC));
    chk(sleep_active, 1'b0);
    wait_sleep(1'b1, 10);
    chk(sleep_active, 1'b1);
    $display("event wake test done");
    respond = 1'b1;
    wd = 1'b1;
    watch(4);
    chk({tr, sleep_active}, 2'b10);
    wait_sleep(1'b1, 12);
    chk(sleep_active, 1'b1);
    respond = 1'b0;
    $display("host answer test done");
    wc = 1'b1;
    busy = 1'b1;
    watch(20);
    chk(8'(n_ntf), 8'h1);
    chk(sleep_active, 1'b0);
    busy = 1'b0;
    watch(38);
    chk(sleep_active, 1'b0);
    wait_sleep(1'b1, 6);
    chk(sleep_active, 1'b1);
    $display("call wake test done");
    want_sleep = 1'b0;
    ringing = 1'b1;
    watch(50);
    chk(8'(n_txt), 8'h3);
    chk(8'(n_low), 8'(3 * LOWC));
    ringing = 1'b0;
    repeat (2) @(negedge sys_clk);
    watch(30);
    chk(8'(n_low), 8'h0);
    $display("ring test done");
    for (int s = 0; s < 5; s++) begin
      net = 2'(s % 4);
      style = (s == 4) ? 2'h1 : 2'(s);
      repeat (3) @(negedge sys_clk);
      for (int c = 0; c < 50; c++) begin
        @(negedge sys_clk);
        sig[s][c] = net_led;
      end
    end
    for (int a = 0; a < 3; a++) chk(8'(sig[a] !== sig[a + 1]), 8'h1);
    chk(8'(sig[4] !== sig[0]), 8'h1);
    $display("blink test done");
    do_reset(1'b0);
    tally_and_finish();
  end
endmodule
